// file: src/rpp_pkg.sv
// Constants and carrier types for the repeater port protection block.
// Assumes a 100 MHz system clock; every cycle count derives from CLK_NS.
package rpp_pkg;

	typedef logic [3:0]  rpp_per_t;  // Receive clock period count
	typedef logic [6:0]  rpp_hys_t;  // Hysteresis count
	typedef logic [10:0] rpp_bt_t;   // Bit time count
	typedef logic [6:0]  rpp_cc_t;   // Consecutive collision count

	// System clock and bit time
	localparam int       CLK_NS       = 10;
	localparam int       BIT10_NS     = 100;
	localparam rpp_per_t BT10_CYC     = rpp_per_t'(BIT10_NS / CLK_NS);

	// Receive clock classification; least times round up, longest down
	localparam int       FAST_MAX_NS  = 60;
	localparam int       SLOW_MIN_NS  = 80;
	localparam int       HYST_NS      = 620;
	localparam rpp_per_t FAST_MAX_CYC = rpp_per_t'(FAST_MAX_NS / CLK_NS);
	localparam rpp_per_t SLOW_MIN_CYC = rpp_per_t'((SLOW_MIN_NS + CLK_NS - 1) / CLK_NS);
	localparam rpp_hys_t HYST_CYC     = rpp_hys_t'((HYST_NS + CLK_NS - 1) / CLK_NS);

	// Partition, jabber and carrier monitor limits; COLL_LIMIT in collisions, the rest in bit times
	localparam rpp_cc_t  COLL_LIMIT   = rpp_cc_t'(64);
	localparam rpp_bt_t  LONGCOL_BT   = rpp_bt_t'(1050);
	localparam rpp_bt_t  UNPART_BT    = rpp_bt_t'(512);
	localparam rpp_bt_t  JAB_SIL_BT   = rpp_bt_t'(97);
	localparam rpp_bt_t  FCAR_BT      = rpp_bt_t'(468);

	// Jabber lengths, shortest legal value of each window
	localparam int       JAB10_US       = 4000;
	localparam int       JAB100_US      = 400;
	localparam int       JAB10_CYC_DEF  = JAB10_US * 1000 / CLK_NS;
	localparam int       JAB100_CYC_DEF = JAB100_US * 1000 / CLK_NS;

	// Nibble codes
	localparam logic [3:0] JAM_NIB = 4'h5;
	localparam logic [3:0] FC_NIB  = 4'hE;

	// Port collision state
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_RX    = 2'b01,
		ST_RXCOL = 2'b10,
		ST_TXCOL = 2'b11
	} rpp_col_e;

	// Static configuration bits
	typedef struct packed {
		logic mismatch_isolate_enable;
		logic partition_disable_bit;
		logic unpartition_on_link_fail_enable;
		logic carrier_monitor_disable;
	} rpp_cfg_s;

	// PHY receive side pins
	typedef struct packed {
		logic       crs;
		logic       rx_dv;
		logic       rx_er;
		logic [3:0] rxd;
		logic       col;
		logic       link_ok;
	} rpp_phy_rx_s;

	// One nibble with its error flag
	typedef struct packed {
		logic       er;
		logic [3:0] d;
	} rpp_nib_s;

	// Status bits
	typedef struct packed {
		logic detected_speed_bit;
		logic speed_mismatch_bit;
		logic mismatch_isolated;
		logic cim_isolated;
		logic partitioned;
		logic rx_jabber;
		logic lockup_silence;
		logic lockup_event;
		logic core_reset;
		logic tx_col;
		logic rx_col;
		logic rx_drop;
	} rpp_stat_s;

endpackage

// file: src/rpp_port_prot.sv
// Per-port protection for one repeater slice port: speed check,
// collision states, partition, jabber and carrier integrity monitor.
// Assumes PHY pins, backplane collision and speed pin are asynchronous;
// configuration and backplane streams come from logic on clk_in.
//
// Overview of operation
// [R1] Speed pin change resets the repeater core
// [R2] Isolate port on speed mismatch when enabled
// [R3] Backplane collision enters transmit collision, sends JAM
// [R4] Lone active port with COL enters receive collision
// [R5] Partition after 64 consecutive non-late collisions
// [R6] At 10 Mb/s, overlong collision partitions
// [R7] Partitioned port stops receive, keeps transmitting
// [R8] 512 clean bit times unpartition the port
// [R9] Partition disable holds partition logic in reset
// [R10] 10 Mb/s jabber inserts 97-bit silences
// [R11] 100 Mb/s jabber cuts off until idle
// [R12] No backplane transmit while receive jabber
// [R13] Measure receive clock, report speed and mismatch
// [R14] Period classes: fast, slow, or hold
// [R15] New speed must persist 620 ns
// [R16] Matching speed change clears mismatch at once
// [R17] Mismatch isolation releases itself automatically
// [R18] Detector starts from speed pin after reset
// [R19] Link fail may unpartition when enabled
// [R20] Two or long false carriers isolate
// [R21] Carrier monitor disable turns monitor off
// [R22] PHY flags false carrier by nibble 1110
// [R23] Partition disable turns partitioning off
`timescale 1ns/100ps
`default_nettype none

module rpp_port_prot
	import rpp_pkg::*;
#(
	parameter int JAB10_CYC  = JAB10_CYC_DEF,  // 10 Mb/s jabber length
	parameter int JAB100_CYC = JAB100_CYC_DEF, // 100 Mb/s jabber length
	parameter int JAB_W      = 19,             // Jabber counter width
	parameter int FIFO_W     = $bits(rpp_nib_s),
	parameter int FIFO_D     = 2
) (
	input  wire logic              clk_in,
	input  wire logic              rst_in,
	input  wire rpp_cfg_s          cfg_in,
	input  wire logic              speed_select_pin_in,
	input  wire logic              rx_clk_in,
	input  wire rpp_phy_rx_s       phy_rx_in,
	input  wire logic              bp_col_in,
	output logic                   bp_rx_valid_out,
	input  wire logic              bp_rx_ready_in,
	output rpp_nib_s               bp_rx_data_out,
	input  wire logic              bp_tx_valid_in,
	output logic                   bp_tx_ready_out,
	input  wire rpp_nib_s          bp_tx_data_in,
	output logic                   tx_en_out,
	output rpp_nib_s               tx_data_out,
	output rpp_stat_s              stat_out
);

	localparam int SW = $bits(rpp_phy_rx_s) + 3;
	localparam int PW = (FIFO_D > 1) ? $clog2(FIFO_D) : 1;
	localparam int CW = $clog2(FIFO_D + 1);

	// Synchronisers; stage one feeds stage two only
	logic [SW-1:0]   s1_r;
	logic [SW-1:0]   s2_r;
	rpp_phy_rx_s     phy;          // Synchronised PHY pins
	logic            rxc_s;        // Synchronised receive clock
	logic            spd_s;        // Speed pin, 1 = 100 Mb/s
	logic            bpc_s;        // Backplane collision
	logic            rxc_d_r;      // Receive clock delayed for edge
	logic            spd_d_r;      // Speed pin delayed for change
	logic            crs_d_r;      // Carrier delayed for end of event

	always_ff @(posedge clk_in) begin
		s1_r <= {phy_rx_in, rx_clk_in, speed_select_pin_in, bp_col_in};
		s2_r <= s1_r;
	end

	assign {phy, rxc_s, spd_s, bpc_s} = s2_r;

	// Edge and change history
	always_ff @(posedge clk_in) begin
		rxc_d_r <= rxc_s;
		spd_d_r <= spd_s; // Tracks the pin in reset too, so release shows no false change
		crs_d_r <= rst_in ? 1'b0 : phy.crs;
	end

	wire rxc_rise = rxc_s & ~rxc_d_r;
	wire spd_chg  = (spd_s != spd_d_r) & ~rst_in;

	// Core reset one cycle after any speed pin change
	logic core_rst_r;
	always_ff @(posedge clk_in) begin
		core_rst_r <= rst_in | spd_chg; // R1
	end
	wire crst = rst_in | core_rst_r;

	// Bit tick: every clock at 100 Mb/s, every tenth at 10 Mb/s
	rpp_per_t bt_cnt_r;
	wire      tick = spd_s | (bt_cnt_r == BT10_CYC - 4'h1);
	always_ff @(posedge clk_in) begin
		if (crst | tick) begin
			bt_cnt_r <= '0;
		end else begin
			bt_cnt_r <= bt_cnt_r + 4'h1;
		end
	end

	// Receive clock period, saturating once it reaches slow class
	rpp_per_t per_r;
	logic     cls_r;      // Latest raw class, 1 = 25 MHz
	logic     ds_r;       // Detected speed after hysteresis
	rpp_hys_t hys_r;      // Time the class has disagreed
	wire fast_hit = rxc_rise & (per_r <= FAST_MAX_CYC);         // R14
	wire slow_hit = per_r == SLOW_MIN_CYC;                      // R14
	wire cls_nxt  = fast_hit ? 1'b1 : (slow_hit ? 1'b0 : cls_r);
	wire hys_done = (cls_r != ds_r) & (hys_r == HYST_CYC - 7'h01);
	wire mismatch = ds_r != spd_s;                               // R13

	// Classifier; a static clock saturates into slow class
	always_ff @(posedge clk_in) begin
		if (rst_in | rxc_rise) begin
			per_r <= {3'h0, ~rst_in}; // R18
		end else if (!slow_hit) begin
			per_r <= per_r + 4'h1;
		end
		cls_r <= rst_in ? spd_s : cls_nxt; // R18
	end

	// Hysteresis; not reset by core reset so the speed pin can be chased
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ds_r  <= spd_s; // R18
			hys_r <= '0;
		end else if (spd_chg && cls_r == spd_s) begin
			ds_r  <= cls_r; // R16
			hys_r <= '0;
		end else if (hys_done) begin
			ds_r  <= cls_r; // R15
			hys_r <= '0;
		end else begin
			hys_r <= (cls_r != ds_r) ? hys_r + 7'h01 : 7'h00; // R15
		end
	end

	// Collision state machine
	rpp_col_e st_r;
	rpp_col_e st_nxt;
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			ST_IDLE: begin
				if (bpc_s) st_nxt = ST_TXCOL; // R3
				else if (phy.crs) st_nxt = phy.col ? ST_RXCOL : ST_RX;
			end
			ST_RX: begin
				if (bpc_s) st_nxt = ST_TXCOL; // R3
				else if (phy.col) st_nxt = ST_RXCOL; // R4
				else if (!phy.crs) st_nxt = ST_IDLE;
			end
			ST_RXCOL: begin
				if (bpc_s) st_nxt = ST_TXCOL;
				else if (!phy.col) st_nxt = phy.crs ? ST_RX : ST_IDLE;
			end
			ST_TXCOL: begin
				if (!bpc_s) st_nxt = phy.crs ? ST_RX : ST_IDLE;
			end
			default: st_nxt = ST_IDLE;
		endcase
	end
	always_ff @(posedge clk_in) begin
		st_r <= crst ? ST_IDLE : st_nxt;
	end

	// Packet and collision timing
	wire     in_col = (st_r == ST_TXCOL) | (st_r == ST_RXCOL);
	wire     act    = phy.crs | bp_tx_valid_in;
	logic    col_d_r;   // Collision seen last cycle
	logic    pcol_r;    // Collision already in this packet
	rpp_bt_t pkt_bt_r;  // Bit times in packet so far
	rpp_bt_t col_bt_r;  // Bit times in current collision
	rpp_cc_t cc_r;      // Consecutive collisions
	logic    part_r;    // Port partitioned
	wire     col_start = in_col & ~col_d_r;
	wire     late      = pkt_bt_r >= UNPART_BT;
	wire     clean     = act & ~pcol_r & ~in_col & tick & (pkt_bt_r == UNPART_BT - 11'h001);
	wire     long_col  = ~spd_s & in_col & tick & (col_bt_r == LONGCOL_BT - 11'h001);
	wire     part_clr  = crst | cfg_in.partition_disable_bit; // R9 R23

	// Packet length and collision length counters
	always_ff @(posedge clk_in) begin
		col_d_r <= ~crst & in_col;
		if (crst | ~act) begin
			pkt_bt_r <= '0;
			pcol_r   <= 1'b0;
		end else begin
			pcol_r <= pcol_r | in_col;
			if (tick && !late) pkt_bt_r <= pkt_bt_r + 11'h001;
		end
		if (crst | ~in_col) col_bt_r <= '0;
		else if (tick && col_bt_r != LONGCOL_BT) col_bt_r <= col_bt_r + 11'h001;
	end

	// Partition; a collision outranks a clean packet in the same cycle
	always_ff @(posedge clk_in) begin
		if (part_clr) begin
			cc_r   <= '0; // R9
			part_r <= 1'b0; // R23
		end else if (col_start && !late) begin
			if (cc_r != COLL_LIMIT) cc_r <= cc_r + 7'h01; // R5
			if (cc_r == COLL_LIMIT - 7'h01) part_r <= 1'b1; // R5
		end else if (long_col) begin
			part_r <= 1'b1; // R6
		end else if (clean) begin
			cc_r <= '0; // R8
			if (phy.link_ok || cfg_in.unpartition_on_link_fail_enable) begin
				part_r <= 1'b0; // R8 R19
			end
		end
	end

	// Jabber: one counter, limit chosen by speed
	logic [JAB_W-1:0] jab_r;
	logic             sil_r;    // 10 Mb/s silence window
	logic             seen_r;   // Lockup already tallied this event
	logic             rxjab_r;  // 100 Mb/s receive jabber
	rpp_bt_t          sil_bt_r;
	wire rx_on   = spd_s ? (phy.crs | phy.rx_dv) : phy.crs;
	wire [JAB_W-1:0] jab_lim = spd_s ? JAB_W'(JAB100_CYC - 1) : JAB_W'(JAB10_CYC - 1);
	wire jab_hit = rx_on & ~sil_r & ~rxjab_r & (jab_r == jab_lim);
	wire sil_end = sil_r & tick & (sil_bt_r == JAB_SIL_BT - 11'h001);
	wire lock_ev = jab_hit & ~spd_s & ~seen_r; // R10

	// Jabber timing and silence insertion
	always_ff @(posedge clk_in) begin
		if (crst | ~rx_on) begin
			jab_r    <= '0;
			sil_r    <= 1'b0;
			seen_r   <= 1'b0;
			rxjab_r  <= 1'b0; // R11
			sil_bt_r <= '0;
		end else if (jab_hit) begin
			jab_r   <= '0;
			sil_r   <= ~spd_s; // R10
			seen_r  <= seen_r | ~spd_s;
			rxjab_r <= spd_s; // R11
		end else if (sil_r) begin
			sil_bt_r <= sil_end ? 11'h000 : sil_bt_r + {10'h000, tick};
			sil_r    <= ~sil_end; // R10
		end else if (!rxjab_r) begin
			jab_r <= jab_r + 1'b1;
		end
	end

	// Carrier integrity monitor, 100 Mb/s only
	logic    fcar_r;    // Current carrier judged false
	logic    good_r;    // Current carrier carried data
	logic    fc1_r;     // One false carrier already seen
	logic    cim_r;     // Isolated by the monitor
	rpp_bt_t fc_bt_r;
	wire cim_off = crst | cfg_in.carrier_monitor_disable | ~spd_s; // R21
	wire fc_now  = ~phy.rx_dv & phy.rx_er & (phy.rxd == FC_NIB); // R22
	wire car_end = crs_d_r & ~phy.crs;
	wire fc_long = fcar_r & tick & (fc_bt_r == FCAR_BT - 11'h001);

	// False carrier counting and long false carrier timer
	always_ff @(posedge clk_in) begin
		if (cim_off) begin
			{fcar_r, good_r, fc1_r, cim_r} <= 4'h0;
			fc_bt_r <= '0;
		end else if (car_end) begin
			fcar_r  <= 1'b0;
			good_r  <= 1'b0;
			fc_bt_r <= '0;
			if (fcar_r) begin
				fc1_r <= 1'b1;
				if (fc1_r) cim_r <= 1'b1; // R20
			end else if (good_r) begin
				fc1_r <= 1'b0;
				cim_r <= 1'b0;
			end
		end else if (phy.crs) begin
			fcar_r <= (fcar_r | fc_now) & ~(good_r | phy.rx_dv);
			good_r <= good_r | phy.rx_dv;
			if (fcar_r && tick && fc_bt_r != FCAR_BT) fc_bt_r <= fc_bt_r + 11'h001;
			if (fc_long) cim_r <= 1'b1; // R20
		end
	end

	// Forwarding gate; mismatch isolation follows the live compare
	wire mm_iso = cfg_in.mismatch_isolate_enable & mismatch; // R2 R17
	wire fwd_ok = ~part_r & ~mm_iso & ~cim_r & ~sil_r & ~rxjab_r; // R7
	wire rx_acc = spd_s ? phy.rx_dv : phy.crs;
	wire push_q = rxc_rise & rx_acc & fwd_ok & ~crst;

	// Two-entry receive buffer toward the backplane
	logic [FIFO_W-1:0] mem_r [FIFO_D];
	logic [PW-1:0]     wp_r;
	logic [PW-1:0]     rp_r;
	logic [CW-1:0]     cnt_r;
	wire in_rdy = cnt_r != CW'(FIFO_D);
	wire do_wr  = push_q & in_rdy;
	wire do_rd  = bp_rx_valid_out & bp_rx_ready_in;
	wire drop   = push_q & ~in_rdy; // The PHY cannot be stalled

	assign bp_rx_valid_out = cnt_r != '0;
	assign bp_rx_data_out  = mem_r[rp_r];

	// Pointer update; storage needs no reset
	always_ff @(posedge clk_in) begin
		if (crst) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (do_wr) wp_r <= (wp_r == PW'(FIFO_D - 1)) ? '0 : wp_r + 1'b1;
			if (do_rd) rp_r <= (rp_r == PW'(FIFO_D - 1)) ? '0 : rp_r + 1'b1;
			cnt_r <= cnt_r + CW'(do_wr) - CW'(do_rd);
		end
		if (do_wr) mem_r[wp_r] <= {phy.rx_er, phy.rxd};
	end

	// Transmit toward the PHY; JAM outranks backplane data
	assign bp_tx_ready_out = ~crst & ~rxjab_r & (st_r != ST_TXCOL); // R12
	always_ff @(posedge clk_in) begin
		if (crst) begin
			tx_en_out   <= 1'b0;
			tx_data_out <= '0;
		end else if (st_r == ST_TXCOL) begin
			tx_en_out   <= 1'b1; // R3
			tx_data_out <= '{er: 1'b0, d: JAM_NIB};
		end else begin
			tx_en_out   <= bp_tx_valid_in & bp_tx_ready_out; // R7 R12
			tx_data_out <= bp_tx_data_in;
		end
	end

	// Registered status
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			stat_out <= '0;
		end else begin
			stat_out <= '{
				detected_speed_bit: ds_r,
				speed_mismatch_bit: mismatch,
				mismatch_isolated:  mm_iso,
				cim_isolated:       cim_r,
				partitioned:        part_r,
				rx_jabber:          rxjab_r,
				lockup_silence:     sil_r,
				lockup_event:       lock_ev,
				core_reset:         core_rst_r,
				tx_col:             st_r == ST_TXCOL,
				rx_col:             st_r == ST_RXCOL,
				rx_drop:            drop
			};
		end
	end

	// Checks on the logic above
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	property p_spd_rst;
		spd_chg |=> core_rst_r ##1 (st_r == ST_IDLE && !part_r);
	endproperty
	a_spd_rst: assert property (p_spd_rst) else $error("no core reset"); // R1

	property p_mm_iso;
		(cfg_in.mismatch_isolate_enable && mismatch) |=> stat_out.mismatch_isolated;
	endproperty
	a_mm_iso: assert property (p_mm_iso) else $error("mismatch not isolated"); // R2

	property p_txcol;
		(bpc_s && !crst) |=> (st_r == ST_TXCOL) ##1 (tx_en_out && tx_data_out.d == JAM_NIB);
	endproperty
	a_txcol: assert property (p_txcol) else $error("no JAM"); // R3

	property p_part64;
		(col_start && !late && cc_r == COLL_LIMIT - 7'h01 && !part_clr) |=> part_r;
	endproperty
	a_part64: assert property (p_part64) else $error("no partition"); // R5

	property p_pdis;
		cfg_in.partition_disable_bit |=> !part_r && cc_r == 7'h00;
	endproperty
	a_pdis: assert property (p_pdis) else $error("partition not held"); // R9

	property p_rxjab;
		rxjab_r |-> !bp_tx_ready_out && !push_q;
	endproperty
	a_rxjab: assert property (p_rxjab) else $error("jabber leak"); // R11

	property p_hyst;
		(ds_r != $past(ds_r) && !$past(spd_chg) && !$past(rst_in))
			|-> $past(hys_r) == HYST_CYC - 7'h01;
	endproperty
	a_hyst: assert property (p_hyst) else $error("early speed flip"); // R15

	property p_fc2;
		(!cim_off && car_end && fcar_r && fc1_r) |=> cim_r;
	endproperty
	a_fc2: assert property (p_fc2) else $error("no isolation"); // R20

	property p_sil;
		$rose(sil_r) |-> sil_r [*8];
	endproperty
	a_sil: assert property (p_sil) else $error("short silence"); // R10

endmodule // rpp_port_prot

`default_nettype wire

// file: bench/rpp_phy_model.sv
// PHY receive side model for the port protection bench.
// Assumes the bench drives collision, link and held carrier levels.
`timescale 1ns/100ps
`default_nettype none

module rpp_phy_model
	import rpp_pkg::*;
(
	input  wire logic   col_in,
	input  wire logic   link_in,
	input  wire logic   hold_in,
	output logic        rx_clk_out,
	output rpp_phy_rx_s phy_rx_out
);
	logic       frm = 1'b0;  // Frame in progress
	logic [3:0] nib = 4'h0;  // Nibble on the data lines
	logic       er  = 1'b0;  // Receive error line

	// Clock stands still between frames, which also reads as slow
	initial begin
		rx_clk_out = 1'b0;
	end

	// Carrier from frame or held level; valid marks frame nibbles only
	assign phy_rx_out = '{crs: frm | hold_in, rx_dv: frm & ~er, rx_er: er,
		rxd: nib, col: col_in, link_ok: link_in};

	// One receive clock period; data moves on the fall only
	task automatic pulse(input int half);
		#(half) rx_clk_out = 1'b1;
		#(half) rx_clk_out = 1'b0;
	endtask

	// Clock burst without carrier, to exercise the speed detector
	task automatic spin(input int n, input int half);
		repeat (n) pulse(half);
	endtask

	// Frame at 80 ns per nibble unless told otherwise; lines inverted once released
	task automatic frame(input logic [3:0] q[$], input int half = 40);
		#3.3;
		frm = 1'b1;
		foreach (q[i]) begin
			nib = q[i];
			pulse(half);
		end
		frm = 1'b0;
		nib = ~nib;
	endtask

	// False carrier as a PHY without its own monitor flags it; clock stays still
	task automatic false_car(input int ns);
		#3.3;
		{frm, er, nib} = {2'b11, FC_NIB};
		#(ns);
		{frm, er} = 2'b00;
		nib = ~nib;
	endtask
endmodule // rpp_phy_model

`default_nettype wire

// file: bench/repeater_port_protection_tb.sv
// Self-checking bench for the repeater port protection block.
// Assumes the design package and the PHY model are compiled first.
`timescale 1ns/100ps
`default_nettype none

module repeater_port_protection_tb
	import rpp_pkg::*;
;
	logic        clk_in = 1'b0;               // System clock
	logic        rst_in = 1'b1;               // Sync reset
	rpp_cfg_s    cfg    = '{1'b1, 1'b0, 1'b0, 1'b0}; // Isolate on mismatch
	logic        spd    = 1'b1;               // Speed pin, starts fast
	logic        bp_col = 1'b0;               // Backplane collision
	logic        rdy    = 1'b1;               // Backplane receive ready
	logic        txv    = 1'b0;               // Backplane transmit valid
	rpp_nib_s    txd    = '0;                 // Backplane transmit word
	logic        col    = 1'b0;               // PHY collision
	logic        link   = 1'b1;               // PHY link good
	logic        hold   = 1'b0;               // Held carrier
	logic        rx_clk;                      // PHY receive clock
	rpp_phy_rx_s phy_rx;                      // PHY pins
	logic        rxv;                         // Receive valid
	rpp_nib_s    rxd;                         // Receive word
	logic        txr;                         // Transmit ready
	logic        tx_en;                       // PHY transmit enable
	rpp_nib_s    tx_d;                        // PHY transmit word
	rpp_stat_s   st;                          // Status
	int          err_count = 0;               // Mismatches
	int          compares  = 0;               // Comparisons
	int          drops = 0, lockups = 0, core_rsts = 0; // Event tallies
	int          runs = 0, run = 0, first_run = 0;      // Silence runs
	rpp_nib_s    got[$];                      // Popped words
	logic [3:0]  q[$];                        // Sent nibbles

	always #5 clk_in = ~clk_in;

	// Short jabber lengths keep the run brief
	rpp_port_prot #(.JAB10_CYC(200), .JAB100_CYC(100)) rpp_port_prot_inst (
		.clk_in(clk_in), .rst_in(rst_in), .cfg_in(cfg), .speed_select_pin_in(spd),
		.rx_clk_in(rx_clk), .phy_rx_in(phy_rx), .bp_col_in(bp_col),
		.bp_rx_valid_out(rxv), .bp_rx_ready_in(rdy), .bp_rx_data_out(rxd),
		.bp_tx_valid_in(txv), .bp_tx_ready_out(txr), .bp_tx_data_in(txd),
		.tx_en_out(tx_en), .tx_data_out(tx_d), .stat_out(st));

	rpp_phy_model rpp_phy_model_inst (.col_in(col), .link_in(link), .hold_in(hold),
		.rx_clk_out(rx_clk), .phy_rx_out(phy_rx));

	// Pops, drop and lockup pulses, core resets, silence run lengths
	always @(posedge clk_in) begin
		if (rxv === 1'b1 && rdy === 1'b1)
			got.push_back(rxd);
		drops <= drops + int'(st.rx_drop === 1'b1);
		lockups <= lockups + int'(st.lockup_event === 1'b1);
		core_rsts <= core_rsts + int'(st.core_reset === 1'b1);
		if (st.lockup_silence === 1'b1)
			run <= run + 1;
		else if (run != 0) begin
			runs <= runs + 1;
			if (runs == 0)
				first_run <= run;
			run <= 0;
		end
	end

	// Only bit 0 and the error flag are compared at 10 Mb/s, the whole nibble at 100
	function automatic logic [4:0] key(input logic er, input logic [3:0] d, input logic wide);
		return {er, wide ? d : {3'h0, d[0]}};
	endfunction

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	task automatic mk(input int n);
		q.delete();
		repeat (n) q.push_back(4'($urandom));
	endtask

	task automatic cmp_rx(input int n, input logic wide = 1'b0);
		chk("rx_count", 16'(got.size()), 16'(n));
		for (int i = 0; i < n && i < got.size(); i++)
			chk("rx_word", key(got[i].er, got[i].d, wide), key(1'b0, q[i], wide));
	endtask

	// Holds valid up; caller releases it after the last word
	task automatic send_tx(input rpp_nib_s w);
		int k;
		txv = 1'b1;
		txd = w;
		for (k = 0; k < 20 && txr !== 1'b1; k++)
			tick(1);
		tick(1);
		chk("tx_out", {tx_en, tx_d}, {1'b1, w});
	endtask

	task automatic tx_burst;
		for (int i = 0; i < 4; i++)
			send_tx(rpp_nib_s'(5'($urandom)));
		txv = 1'b0;
		tick(2);
	endtask

	task automatic collide(input int n);
		repeat (n) begin
			hold = 1'b1;
			tick(5);
			bp_col = 1'b1;
			tick(10);
			bp_col = 1'b0;
			hold = 1'b0;
			tick(10);
		end
	endtask

	task automatic final_report;
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Hang guard, well beyond the expected run
	initial begin
		#1_000_000;
		err_count++;
		final_report();
	end

	initial begin
		void'($urandom(32'hDDBD));
		repeat (3) @(posedge clk_in);
		#1 rst_in = 1'b0;
		tick(3);
		chk("ds_reset", {st.detected_speed_bit, st.speed_mismatch_bit}, 2'b10);
		tick(27);
		chk("ds_hyst", st.detected_speed_bit, 1'b1);
		tick(70);
		chk("ds_static", {st.detected_speed_bit, st.speed_mismatch_bit}, 2'b01);
		chk("iso_on", st.mismatch_isolated, 1'b1);
		core_rsts = 0;
		spd = 1'b0;
		tick(6);
		chk("iso_off", {st.speed_mismatch_bit, st.mismatch_isolated}, 2'b00);
		chk("core_rst", 16'(core_rsts), 16'd1);
		rpp_phy_model_inst.spin(30, 20);
		tick(2);
		chk("ds_fast", {st.detected_speed_bit, st.speed_mismatch_bit}, 2'b11);
		rpp_phy_model_inst.spin(30, 35);
		chk("ds_holds", st.detected_speed_bit, 1'b1);
		tick(100);
		chk("ds_back", {st.detected_speed_bit, st.speed_mismatch_bit}, 2'b00);
		// Stalled backplane: two words kept, the rest dropped
		rdy = 1'b0;
		mk(6);
		rpp_phy_model_inst.frame(q);
		tick(10);
		chk("drops", 16'(drops), 16'd4);
		rdy = 1'b1;
		tick(5);
		cmp_rx(2);
		// Random stalls lose nothing
		got.delete();
		mk(8);
		fork
			rpp_phy_model_inst.frame(q);
			repeat (70) begin
				rdy = 1'($urandom);
				tick(1);
			end
		join
		rdy = 1'b1;
		tick(10);
		cmp_rx(8);
		tx_burst();
		hold = 1'b1;
		tick(5);
		bp_col = 1'b1;
		tick(8);
		chk("tx_col", {st.tx_col, txr}, 2'b10);
		chk("jam", {tx_en, tx_d.d}, {1'b1, JAM_NIB});
		bp_col = 1'b0;
		hold = 1'b0;
		tick(10);
		collide(62);
		chk("part_63", st.partitioned, 1'b0);
		collide(1);
		tick(5);
		chk("part_64", st.partitioned, 1'b1);
		got.delete();
		mk(3);
		rpp_phy_model_inst.frame(q);
		tick(10);
		chk("part_rx", 16'(got.size()), 16'd0);
		tx_burst();
		hold = 1'b1;
		tick(4900);
		chk("unpart_early", st.partitioned, 1'b1);
		tick(400);
		chk("unpart", st.partitioned, 1'b0);
		hold = 1'b0;
		tick(10);
		cfg.partition_disable_bit = 1'b1;
		collide(64);
		chk("part_off", st.partitioned, 1'b0);
		cfg.partition_disable_bit = 1'b0;
		hold = 1'b1;
		col = 1'b1;
		tick(8);
		chk("rx_col", st.rx_col, 1'b1);
		col = 1'b0;
		hold = 1'b0;
		tick(10);
		// Long carrier at 10 Mb/s
		lockups = 0;
		runs = 0;
		hold = 1'b1;
		tick(2500);
		hold = 1'b0;
		tick(50);
		chk("lockups", 16'(lockups), 16'd1);
		chk("silences", runs >= 2, 1'b1);
		chk("sil_len", first_run inside {[960:970]}, 1'b1);
		// Collision past the long collision timer, then unpartition on link fail
		bp_col = 1'b1;
		tick(10400);
		chk("longcol_early", st.partitioned, 1'b0);
		tick(300);
		chk("longcol", st.partitioned, 1'b1);
		bp_col = 1'b0;
		link = 1'b0;
		tick(10);
		for (int u = 0; u < 2; u++) begin
			cfg.unpartition_on_link_fail_enable = u[0];
			hold = 1'b1;
			tick(5300);
			chk("ulf", st.partitioned, !u[0]);
			hold = 1'b0;
			tick(10);
		end
		link = 1'b1;
		// 100 Mb/s: whole nibbles, receive jabber, carrier monitor
		cfg.mismatch_isolate_enable = 1'b0;
		spd = 1'b1;
		tick(10);
		got.delete();
		mk(8);
		rpp_phy_model_inst.frame(q, 20);
		tick(10);
		cmp_rx(8, 1'b1);
		hold = 1'b1;
		tick(120);
		chk("rx_jab", {st.rx_jabber, txr}, 2'b10);
		hold = 1'b0;
		tick(6);
		chk("jab_end", {st.rx_jabber, txr}, 2'b01);
		rpp_phy_model_inst.false_car(100);
		tick(5);
		chk("fc_one", st.cim_isolated, 1'b0);
		rpp_phy_model_inst.false_car(100);
		tick(5);
		chk("fc_two", st.cim_isolated, 1'b1);
		cfg.carrier_monitor_disable = 1'b1;
		tick(3);
		chk("cim_off", st.cim_isolated, 1'b0);
		cfg.carrier_monitor_disable = 1'b0;
		rpp_phy_model_inst.false_car(5000);
		chk("fc_long", st.cim_isolated, 1'b1);
		final_report();
	end
endmodule // repeater_port_protection_tb

`default_nettype wire
